// ### lcd_timing_pkg.sv
// Constants and types shared by the LCD display timing generator
package lcd_timing_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS      = 8'h00;
   localparam logic [7:0] POWER_OFS     = 8'h04;
   localparam logic [7:0] LINE_REV_OFS  = 8'h08;
   localparam logic [7:0] START_OFS     = 8'h0C;
   localparam logic [7:0] STATUS_OFS    = 8'h10;

   // Control register field positions
   localparam int CTRL_DISP_ON   = 0;
   localparam int CTRL_INVERT    = 1;
   localparam int CTRL_ALL_ON    = 2;
   localparam int CTRL_SCAN_REV  = 3;
   localparam int CTRL_OSC_ON    = 4;
   localparam int CTRL_W         = 5;

   // Line reversal register fields
   localparam int LREV_VAL_W     = 5;
   localparam int LREV_EN_BIT    = 5;

   // Status register field positions
   localparam int STAT_LINE_LSB  = 0;
   localparam int STAT_POL_BIT   = 8;
   localparam int STAT_SYNC_BIT  = 9;
   localparam int STAT_OSC_BIT   = 10;
   localparam int STAT_PWR_LSB   = 12;

   // Reset values
   localparam logic [CTRL_W-1:0]     CTRL_RST  = 5'h00;
   localparam logic [2:0]            POWER_RST = 3'h0;
   localparam logic [LREV_VAL_W-1:0] LREV_RST  = 5'h00;
   localparam logic [6:0]            START_RST = 7'h00;

   // Geometry
   localparam int         NUM_COLS  = 289;
   localparam int         NUM_ROWS  = 65;
   localparam logic [6:0] LAST_LINE = 7'h40;
   localparam logic [6:0] LAST_SCAN = 7'h3F;

   // Internal oscillator half period in reference clock cycles
   localparam logic [15:0] OSC_HALF = 16'h0064;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b01,
      WR_RESP = 2'b10
   } wr_state_t;

endpackage

// ### lcd_display_timing_generator.sv
// LCD display timing generator with display latch and AXI4-Lite registers
//
// How it works
// - Display commands alter latch only, never memory
// - Oscillator needs master, internal source, on command
// - External source: oscillator stops, line clock from pin
// - Latch row data, drive columns per clock
// - Refresh reads independent of host accesses
// - Polarity toggles each frame: two-frame drive
// - Stored n-1 inverts polarity every n lines
// - Frame align is 50 percent frame-locked square
// - Slave aligns line counter to frame align
// - Pin directions by master/slave and clock source
// - Scan rows 0 up to 63, or reversed
// - Four drive levels from data, row, polarity
// - Power enables act only in master mode
// - Power bits: booster, regulator, follower
// - 65 displayed lines from programmed start line
`timescale 1ns/10ps
`default_nettype none

module lcd_display_timing_generator (
   input  wire logic                    ref_clk_i,
   input  wire logic                    rst_n_i,
   input  wire logic [31:0]             s_axi_awaddr_i,
   input  wire logic                    s_axi_awvalid_i,
   output var  logic                    s_axi_awready_o,
   input  wire logic [31:0]             s_axi_wdata_i,
   input  wire logic [3:0]              s_axi_wstrb_i,
   input  wire logic                    s_axi_wvalid_i,
   output var  logic                    s_axi_wready_o,
   output var  logic [1:0]              s_axi_bresp_o,
   output var  logic                    s_axi_bvalid_o,
   input  wire logic                    s_axi_bready_i,
   input  wire logic [31:0]             s_axi_araddr_i,
   input  wire logic                    s_axi_arvalid_i,
   output var  logic                    s_axi_arready_o,
   output var  logic [31:0]             s_axi_rdata_o,
   output var  logic [1:0]              s_axi_rresp_o,
   output var  logic                    s_axi_rvalid_o,
   input  wire logic                    s_axi_rready_i,
   input  wire logic                    master_slave_select_i,
   input  wire logic                    clock_source_select_i,
   output var  logic [6:0]              mem_row_addr_o,
   input  wire logic [288:0]            mem_row_data_i,
   input  wire logic                    line_timing_pin_i,
   output var  logic                    line_timing_pin_o,
   output var  logic                    line_timing_pin_oe_o,
   input  wire logic                    ac_polarity_signal_i,
   output var  logic                    ac_polarity_signal_o,
   output var  logic                    ac_polarity_signal_oe_o,
   input  wire logic                    frame_align_signal_i,
   output var  logic                    frame_align_signal_o,
   output var  logic                    frame_align_signal_oe_o,
   input  wire logic                    display_off_signal_i,
   output var  logic                    display_off_signal_o,
   output var  logic                    display_off_signal_oe_o,
   output var  logic [577:0]            column_driver_output_o,
   output var  logic [129:0]            row_driver_output_o,
   output var  logic [2:0]              power_enable_o
);

   typedef struct packed {
      lcd_timing_pkg::wr_state_t wst;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        aw_got;
      logic        w_got;
      logic [31:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [4:0]  ctrl;
      logic [2:0]  power;
      logic        lrev_en;
      logic [4:0]  lrev_val;
      logic [6:0]  start;
      logic [15:0] osc_cnt;
      logic        osc_run;
      logic        lt_out;
      logic        lt_prev;
      logic        fa_prev;
      logic [6:0]  line;
      logic [4:0]  lrev_cnt;
      logic        pol;
      logic        sync;
      logic        disp_off;
      logic        lt_oe;
      logic        tim_oe;
      logic [6:0]  mem_addr;
      logic [288:0] latch;
      logic [577:0] col_out;
      logic [129:0] row;
      logic [2:0]  pwr;
   } state_t;

   state_t st;
   state_t next_st;

   // Wrap an address into the 65-line display area
   function automatic logic [6:0] wrap_line(input logic [7:0] a);
      logic [7:0] r;
      r = (a > {1'b0, lcd_timing_pkg::LAST_LINE}) ? (a - 8'h41) : a;
      return r[6:0];
   endfunction

   // Byte-lane merge of write data
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   logic master;
   logic osc_sel;
   logic ext_edge;
   logic osc_tick;
   logic line_tick;
   logic frame_end;

   assign master    = master_slave_select_i;
   assign osc_sel   = clock_source_select_i;
   assign ext_edge  = line_timing_pin_i & ~st.lt_prev;
   assign osc_tick  = st.osc_run && (st.osc_cnt == lcd_timing_pkg::OSC_HALF - 16'h0001)
                      && !st.lt_out;
   assign line_tick = (master && osc_sel) ? osc_tick : ext_edge;
   assign frame_end = line_tick && (st.line == lcd_timing_pkg::LAST_LINE);

   always_comb begin
      logic [31:0] wreg;
      logic [31:0] rval;
      logic        hit;
      logic [6:0]  scan_row;
      logic        pix;
      logic        on;
      wreg     = 32'h0000_0000;
      rval     = 32'h0000_0000;
      hit      = 1'b1;
      scan_row = 7'h00;
      pix      = 1'b0;
      on       = 1'b0;
      next_st  = st;

      // Register writes
      unique case (st.wst)
         lcd_timing_pkg::WR_IDLE: begin
            if (s_axi_awvalid_i && st.awready) begin
               next_st.aw_got  = 1'b1;
               next_st.aw_addr = s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && st.wready) begin
               next_st.w_got  = 1'b1;
               next_st.w_data = s_axi_wdata_i;
               next_st.w_strb = s_axi_wstrb_i;
            end
            if (next_st.aw_got && next_st.w_got) begin
               next_st.bresp = lcd_timing_pkg::RESP_OKAY;
               if (next_st.aw_addr[31:8] != 24'h000000) begin
                  next_st.bresp = lcd_timing_pkg::RESP_SLVERR;
               end else begin
                  unique case (next_st.aw_addr[7:0])
                     lcd_timing_pkg::CTRL_OFS: begin
                        wreg = merge({27'h0, st.ctrl}, next_st.w_data, next_st.w_strb);
                        next_st.ctrl = wreg[4:0];
                     end
                     lcd_timing_pkg::POWER_OFS: begin
                        wreg = merge({29'h0, st.power}, next_st.w_data, next_st.w_strb);
                        next_st.power = wreg[2:0];
                     end
                     lcd_timing_pkg::LINE_REV_OFS: begin
                        wreg = merge({26'h0, st.lrev_en, st.lrev_val}, next_st.w_data,
                                     next_st.w_strb);
                        next_st.lrev_val = wreg[4:0];
                        next_st.lrev_en  = wreg[lcd_timing_pkg::LREV_EN_BIT];
                     end
                     lcd_timing_pkg::START_OFS: begin
                        wreg = merge({25'h0, st.start}, next_st.w_data, next_st.w_strb);
                        next_st.start = wrap_line({1'b0, wreg[6:0]});
                     end
                     lcd_timing_pkg::STATUS_OFS: ;
                     default: next_st.bresp = lcd_timing_pkg::RESP_SLVERR;
                  endcase
               end
               next_st.bvalid = 1'b1;
               next_st.wst    = lcd_timing_pkg::WR_RESP;
            end
         end
         lcd_timing_pkg::WR_RESP: begin
            if (s_axi_bready_i) begin
               next_st.bvalid = 1'b0;
               next_st.aw_got = 1'b0;
               next_st.w_got  = 1'b0;
               next_st.wst    = lcd_timing_pkg::WR_IDLE;
            end
         end
         default: next_st.wst = lcd_timing_pkg::WR_IDLE;
      endcase
      next_st.awready = (next_st.wst == lcd_timing_pkg::WR_IDLE) && !next_st.aw_got;
      next_st.wready  = (next_st.wst == lcd_timing_pkg::WR_IDLE) && !next_st.w_got;

      // Register reads
      if (st.rvalid && s_axi_rready_i) begin
         next_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && st.arready) begin
         unique case (s_axi_araddr_i[7:0])
            lcd_timing_pkg::CTRL_OFS:     rval = {27'h0, st.ctrl};
            lcd_timing_pkg::POWER_OFS:    rval = {29'h0, st.power};
            lcd_timing_pkg::LINE_REV_OFS: rval = {26'h0, st.lrev_en, st.lrev_val};
            lcd_timing_pkg::START_OFS:    rval = {25'h0, st.start};
            lcd_timing_pkg::STATUS_OFS: begin
               rval[lcd_timing_pkg::STAT_LINE_LSB +: 7] = st.line;
               rval[lcd_timing_pkg::STAT_POL_BIT]       = st.pol;
               rval[lcd_timing_pkg::STAT_SYNC_BIT]      = st.sync;
               rval[lcd_timing_pkg::STAT_OSC_BIT]       = st.osc_run;
               rval[lcd_timing_pkg::STAT_PWR_LSB +: 3]  = st.pwr;
            end
            default: hit = 1'b0;
         endcase
         if (s_axi_araddr_i[31:8] != 24'h000000) begin
            hit = 1'b0;
         end
         next_st.rvalid = 1'b1;
         next_st.rdata  = hit ? rval : 32'h0000_0000;
         next_st.rresp  = hit ? lcd_timing_pkg::RESP_OKAY : lcd_timing_pkg::RESP_SLVERR;
      end
      next_st.arready = !next_st.rvalid;

      // Internal oscillator
      next_st.osc_run = master && osc_sel && st.ctrl[lcd_timing_pkg::CTRL_OSC_ON];
      if (st.osc_run) begin
         if (st.osc_cnt == lcd_timing_pkg::OSC_HALF - 16'h0001) begin
            next_st.osc_cnt = 16'h0000;
            next_st.lt_out  = !st.lt_out;
         end else begin
            next_st.osc_cnt = st.osc_cnt + 16'h0001;
         end
      end else begin
         next_st.osc_cnt = 16'h0000;
         next_st.lt_out  = 1'b0;
      end
      next_st.lt_prev = line_timing_pin_i;
      next_st.fa_prev = frame_align_signal_i;

      // Line counter, frame align and polarity
      if (line_tick) begin
         next_st.line = frame_end ? 7'h00 : st.line + 7'h01;
      end
      if (master) begin
         if (frame_end) begin
            next_st.sync = !st.sync;
         end
         if (st.lrev_en) begin
            if (line_tick) begin
               if (st.lrev_cnt >= st.lrev_val) begin
                  next_st.lrev_cnt = 5'h00;
                  next_st.pol      = !st.pol;
               end else begin
                  next_st.lrev_cnt = st.lrev_cnt + 5'h01;
               end
            end
         end else begin
            next_st.lrev_cnt = 5'h00;
            if (frame_end) begin
               next_st.pol = !st.pol;
            end
         end
         next_st.disp_off = !st.ctrl[lcd_timing_pkg::CTRL_DISP_ON];
      end else begin
         next_st.pol      = ac_polarity_signal_i;
         next_st.sync     = frame_align_signal_i;
         next_st.disp_off = display_off_signal_i;
         next_st.lrev_cnt = 5'h00;
         if (frame_align_signal_i != st.fa_prev) begin
            next_st.line = 7'h00;
         end
      end
      next_st.tim_oe = master;
      next_st.lt_oe  = master && osc_sel;

      // Refresh fetch, independent of the register bus
      if (line_tick) begin
         next_st.latch    = mem_row_data_i;
         next_st.mem_addr = wrap_line({1'b0, st.start} + {1'b0, next_st.line} + 8'h01);
      end
      if (!master && (frame_align_signal_i != st.fa_prev)) begin
         next_st.mem_addr = wrap_line({1'b0, st.start} + 8'h01);
      end

      // Drive multiplexers; display commands act on latch copy only
      on = !st.disp_off;
      if (st.line == lcd_timing_pkg::LAST_LINE) begin
         scan_row = lcd_timing_pkg::LAST_LINE;
      end else if (st.ctrl[lcd_timing_pkg::CTRL_SCAN_REV]) begin
         scan_row = lcd_timing_pkg::LAST_SCAN - st.line;
      end else begin
         scan_row = st.line;
      end
      for (int c = 0; c < lcd_timing_pkg::NUM_COLS; c++) begin
         pix = st.ctrl[lcd_timing_pkg::CTRL_ALL_ON] ||
               (st.latch[c] ^ st.ctrl[lcd_timing_pkg::CTRL_INVERT]);
         next_st.col_out[c*2 +: 2] = {st.pol, pix && on};
      end
      for (int r = 0; r < lcd_timing_pkg::NUM_ROWS; r++) begin
         next_st.row[r*2 +: 2] = {st.pol, on && (scan_row == r[6:0])};
      end

      next_st.pwr = master ? st.power : 3'h0;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st          <= '0;
         st.wst      <= lcd_timing_pkg::WR_IDLE;
         st.awready  <= 1'b1;
         st.wready   <= 1'b1;
         st.arready  <= 1'b1;
         st.ctrl     <= lcd_timing_pkg::CTRL_RST;
         st.power    <= lcd_timing_pkg::POWER_RST;
         st.lrev_val <= lcd_timing_pkg::LREV_RST;
         st.start    <= lcd_timing_pkg::START_RST;
         st.mem_addr <= lcd_timing_pkg::START_RST + 7'h01;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready_o         = st.awready;
   assign s_axi_wready_o          = st.wready;
   assign s_axi_bresp_o           = st.bresp;
   assign s_axi_bvalid_o          = st.bvalid;
   assign s_axi_arready_o         = st.arready;
   assign s_axi_rdata_o           = st.rdata;
   assign s_axi_rresp_o           = st.rresp;
   assign s_axi_rvalid_o          = st.rvalid;
   assign mem_row_addr_o          = st.mem_addr;
   assign line_timing_pin_o       = st.lt_out;
   assign line_timing_pin_oe_o    = st.lt_oe;
   assign ac_polarity_signal_o    = st.pol;
   assign ac_polarity_signal_oe_o = st.tim_oe;
   assign frame_align_signal_o    = st.sync;
   assign frame_align_signal_oe_o = st.tim_oe;
   assign display_off_signal_o    = st.disp_off;
   assign display_off_signal_oe_o = st.tim_oe;
   assign column_driver_output_o  = st.col_out;
   assign row_driver_output_o     = st.row;
   assign power_enable_o          = st.pwr;

   chk_osc_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      st.osc_run |-> $past(master && osc_sel && st.ctrl[lcd_timing_pkg::CTRL_OSC_ON]))
      else $error("oscillator ran without master, source and on command");
   chk_osc_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !osc_sel |=> !st.osc_run ##1 !line_timing_pin_o)
      else $error("oscillator kept running with external clock selected");
   chk_slave_pins: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !master |=> !ac_polarity_signal_oe_o && !frame_align_signal_oe_o
                  && !display_off_signal_oe_o && !line_timing_pin_oe_o)
      else $error("slave drove a timing pin");
   chk_master_pins: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      master && rst_n_i |=> ac_polarity_signal_oe_o && (line_timing_pin_oe_o == $past(osc_sel)))
      else $error("master timing pin direction wrong");
   chk_power_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !master |=> power_enable_o == 3'h0)
      else $error("power enables active in slave mode");
   chk_power_bits: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      master |=> power_enable_o == $past(st.power))
      else $error("power enables do not follow register");
   chk_sync_frame: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      master && frame_end |=> frame_align_signal_o != $past(frame_align_signal_o))
      else $error("frame align did not toggle at frame end");
   chk_frame_pol: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      master && !st.lrev_en && line_tick && !frame_end |=>
      ac_polarity_signal_o == $past(ac_polarity_signal_o))
      else $error("polarity changed mid frame");
   chk_line_rev: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      master && st.lrev_en && line_tick && (st.lrev_cnt == st.lrev_val) |=>
      ac_polarity_signal_o != $past(ac_polarity_signal_o))
      else $error("polarity not inverted after n lines");
   chk_latch_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      line_tick |=> st.latch == $past(mem_row_data_i))
      else $error("display latch not loaded on line clock");

endmodule // lcd_display_timing_generator

`default_nettype wire

// ### lcd_panel_model.sv
// Panel and master-chip stand-in: row data source and resolved timing pins
`timescale 1ns/10ps
`default_nettype none
module lcd_panel_model (
   input  wire logic         ext_line_i,
   input  wire logic [6:0]   row_addr_i,
   output var  logic [288:0] row_data_o,
   input  wire logic [3:0]   pin_o_i,
   input  wire logic [3:0]   pin_oe_i,
   output var  logic [3:0]   pin_i_o
);
   logic [1:0] ext_cnt;
   initial ext_cnt = 2'h0;
   always @(posedge ext_line_i) ext_cnt <= ext_cnt + 2'h1;
   // Row pattern: bit 0 of every row equals bit 0 of its address
   assign row_data_o = {2'h2, {41{row_addr_i}}};
   // Foreign master drives line, polarity, frame, display-off when ours is quiet
   always_comb begin
      logic [3:0] ext;
      ext = {1'b1, ext_cnt, ext_line_i};
      for (int k = 0; k < 4; k++) pin_i_o[k] = pin_oe_i[k] ? pin_o_i[k] : ext[k];
   end
endmodule // lcd_panel_model
`default_nettype wire

// ### lcd_display_timing_generator_tb.sv
// Self-checking bench for the LCD display timing generator
`timescale 1ns/10ps
`default_nettype none
module lcd_display_timing_generator_tb;
   logic         clk, rst_n, msel, csel, ext_line;
   logic [31:0]  awaddr, wdata, araddr, rdata;
   logic         awvalid, awready, wvalid, wready, bvalid, bready;
   logic         arvalid, arready, rvalid, rready;
   logic [1:0]   bresp, rresp;
   logic [3:0]   wstrb, pin_o, pin_oe, pin_in;
   logic [6:0]   row_addr, s;
   logic [288:0] row_data;
   logic [577:0] col;
   logic [129:0] row;
   logic [2:0]   pwr;
   logic         p;
   int           n_errors, n_compared, t;
   logic [65:0]  exp_r[$];
   logic [65:0]  exp_b[$];

   lcd_display_timing_generator lcd_display_timing_generator_inst (
      .ref_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .master_slave_select_i(msel), .clock_source_select_i(csel),
      .mem_row_addr_o(row_addr), .mem_row_data_i(row_data),
      .line_timing_pin_i(pin_in[0]), .line_timing_pin_o(pin_o[0]),
      .line_timing_pin_oe_o(pin_oe[0]), .ac_polarity_signal_i(pin_in[1]),
      .ac_polarity_signal_o(pin_o[1]), .ac_polarity_signal_oe_o(pin_oe[1]),
      .frame_align_signal_i(pin_in[2]), .frame_align_signal_o(pin_o[2]),
      .frame_align_signal_oe_o(pin_oe[2]), .display_off_signal_i(pin_in[3]),
      .display_off_signal_o(pin_o[3]), .display_off_signal_oe_o(pin_oe[3]),
      .column_driver_output_o(col), .row_driver_output_o(row), .power_enable_o(pwr));

   lcd_panel_model lcd_panel_model_inst (
      .ext_line_i(ext_line), .row_addr_i(row_addr), .row_data_o(row_data),
      .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pin_i_o(pin_in));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic cmp_pin(input logic [6:0] got, input logic [6:0] e);
      n_compared++;
      if (got !== e) begin
         n_errors++;
         $display("[FAIL] %0t pin got %h exp %h", $time, got, e);
      end
   endtask

   // Entry layout: {mask, resp, data}
   task automatic cmp_bus(input logic [33:0] got, input logic [65:0] e);
      n_compared++;
      if (((got ^ e[33:0]) & {2'h3, e[65:34]}) !== 34'h0) begin
         n_errors++;
         $display("[FAIL] %0t bus got %h exp %h", $time, got, e[33:0]);
      end
   endtask

   always @(posedge clk) begin
      if (rvalid && rready && exp_r.size() > 0) cmp_bus({rresp, rdata}, exp_r.pop_front());
      if (bvalid && bready && exp_b.size() > 0) cmp_bus({bresp, 32'h0}, exp_b.pop_front());
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      exp_b.push_back({32'h0, r, 32'h0});
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [33:0] e);
      exp_r.push_back({m, e});
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      @(posedge clk);
   endtask

   // n external line clock periods, each 3 cycles high then 5 low, idle low between periods
   task automatic tick(input int n);
      repeat (n) begin
         ext_line <= 1'b1;
         repeat (3) @(posedge clk);
         ext_line <= 1'b0;
         repeat (5) @(posedge clk);
      end
   endtask

   task automatic report_and_stop;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      report_and_stop;
   end

   initial begin
      {rst_n, csel, ext_line, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
      {awaddr, wdata, araddr} = 96'h0;
      msel = 1'b1;
      wstrb = 4'hF;
      n_errors = 0;
      n_compared = 0;
      s = 7'($urandom(32'hBD51) % 65);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(lcd_timing_pkg::CTRL_OFS, 32'h1F, 34'h0);
      rd(lcd_timing_pkg::POWER_OFS, 32'h7, 34'h0);
      rd(lcd_timing_pkg::LINE_REV_OFS, 32'h3F, 34'h0);
      rd(lcd_timing_pkg::STATUS_OFS, 32'h747F, 34'h0);
      rd(8'h14, 32'hFFFFFFFF, {2'h2, 32'h0});
      wr(8'h14, 32'h1, 2'h2);
      cmp_pin(7'(pin_oe), 7'hE);
      wr(lcd_timing_pkg::CTRL_OFS, 32'h1, 2'h0);
      cmp_pin(7'(pin_o[3]), 7'h0);
      tick(2);
      rd(lcd_timing_pkg::STATUS_OFS, 32'h7F, 34'h2);
      cmp_pin({5'h0, row[4], col[0]}, 7'h2);
      tick(1);
      cmp_pin(7'(col[0]), 7'h1);
      wr(lcd_timing_pkg::CTRL_OFS, 32'h3, 2'h0);
      tick(1);
      cmp_pin({5'h0, row[8], col[0]}, 7'h3);
      wr(lcd_timing_pkg::CTRL_OFS, 32'h9, 2'h0);
      tick(1);
      cmp_pin({5'h0, row[116], col[0]}, 7'h3);
      tick(59);
      cmp_pin(7'(pin_o[2:1]), 7'h0);
      tick(1);
      cmp_pin(7'(pin_o[2:1]), 7'h3);
      rd(lcd_timing_pkg::STATUS_OFS, 32'h37F, 34'h300);
      wr(lcd_timing_pkg::LINE_REV_OFS, 32'h24, 2'h0);
      p = pin_o[1];
      t = 0;
      repeat (20) begin
         tick(1);
         if (pin_o[1] !== p) t++;
         p = pin_o[1];
      end
      cmp_pin(7'(t), 7'h4);
      wr(lcd_timing_pkg::START_OFS, 32'(s), 2'h0);
      rd(lcd_timing_pkg::START_OFS, 32'h7F, 34'(s));
      tick(1);
      cmp_pin(row_addr, 7'((s + 22) % 65));
      for (int k = 0; k < 8; k++) begin
         wr(lcd_timing_pkg::POWER_OFS, 32'(k), 2'h0);
         cmp_pin(7'(pwr), 7'(k));
      end
      msel <= 1'b0;
      repeat (3) @(posedge clk);
      cmp_pin({pin_oe, pwr}, 7'h0);
      tick(1);
      rd(lcd_timing_pkg::STATUS_OFS, 32'h37F, 34'h316);
      cmp_pin(7'(pin_o[3]), 7'h1);
      tick(1);
      rd(lcd_timing_pkg::STATUS_OFS, 32'h37F, 34'h0);
      cmp_pin(row_addr, 7'((s + 1) % 65));
      msel <= 1'b1;
      csel <= 1'b1;
      wr(lcd_timing_pkg::CTRL_OFS, 32'h1, 2'h0);
      repeat (450) @(posedge clk);
      rd(lcd_timing_pkg::STATUS_OFS, 32'h400, 34'h0);
      cmp_pin(7'(pin_oe), 7'hF);
      wr(lcd_timing_pkg::CTRL_OFS, 32'h11, 2'h0);
      repeat (450) @(posedge clk);
      rd(lcd_timing_pkg::STATUS_OFS, 32'h400, 34'h400);
      csel <= 1'b0;
      repeat (3) @(posedge clk);
      rd(lcd_timing_pkg::STATUS_OFS, 32'h400, 34'h0);
      cmp_pin(7'(pin_oe[0]), 7'h0);
      wr(lcd_timing_pkg::CTRL_OFS, 32'h5, 2'h0);
      tick(1);
      cmp_pin({5'h0, col[576], col[0]}, 7'h3);
      report_and_stop;
   end
endmodule // lcd_display_timing_generator_tb
`default_nettype wire
